// [verilog/mib_counter_indirect_access.sv]
// per-port statistics counters behind a byte-wide indirect window
// assumes: host register strobes and frame reports synchronous to clock
//
// Overview of operation
// - offset 0x30 write triggers read, upper byte appears
// - offset 0x31 then data byte commits low
// - 32 counters per port, five port bases
// - slot 0 adds rx high-priority octets
// - short frames split by checksum good/bad
// - slot 3 counts good over-long frames
// - slot 4 counts errored or very long frames
// - slot 5 counts invalid data symbol frames
// - bad checksum whole versus partial byte
// - slot 8 counts mac control frames
// - slot 9 counts qualified pause frames
// - good broadcast, multicast, unicast received frames
// - received length histogram, bad frames included
// - slot 21 adds tx high-priority octets
// - slot 22 counts late collisions
// - tx pause and good cast counters
// - slot 27 counts postponed first attempts
// - all collisions and excessive collision drops
// - sent after one or several collisions
// - word carries overflow, valid, 30-bit count
// - reading a counter clears it
// - word read bytewise from five registers
`timescale 1ns/1ps
module mib_counter_indirect_access (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [mib_pkg::REG_AW-1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   input wire logic frm_valid_i,
   output logic frm_ready_o,
   input wire logic [2:0] frm_port_i,
   input wire logic frm_tx_i,
   input wire logic [mib_pkg::LEN_W-1:0] frm_len_i,
   input wire logic frm_crc_bad_i,
   input wire logic frm_partial_i,
   input wire logic frm_symbol_bad_i,
   input wire logic frm_hi_prio_i,
   input wire logic frm_bcast_i,
   input wire logic frm_mcast_i,
   input wire logic frm_ctrl_type_i,
   input wire logic frm_pause_i,
   input wire logic frm_late_hit_i,
   input wire logic frm_postponed_i,
   input wire logic frm_too_many_i,
   input wire logic [4:0] frm_hits_i,
   input wire logic max_1536_i,
   output logic [15:0] energy_global_o
);
   import mib_pkg::*;

   typedef struct packed {
      state_t st;
      logic [7:0] ctl;
      logic [7:0] off;
      logic [7:0] dbyte;
      logic [7:0] rdata;
      logic [39:0] word;
      logic [15:0] energy;
      logic host_pend;
      logic [7:0] host_addr;
      logic [31:0] mask;
      logic [2:0] port;
      logic [LEN_W-1:0] len;
      logic [4:0] hits;
      logic [7:0] cur_addr;
      logic [4:0] cur_slot;
      logic ready;
   } regs_t;

   regs_t s_ff;
   regs_t nxt_s;

   store_if #(.AW(STORE_AW), .DW(STORE_W)) store ();

   mib_counter_store #(
      .DEPTH(STORE_DEPTH)
   ) u_store (
      .ref_clk_i(ref_clk_i),
      .bus(store.mem)
   );

   // ****************************************
   // helpers
   // ****************************************
   // lowest pending slot; serving in slot order keeps it fair
   function automatic logic [4:0] first_slot(input logic [31:0] m);
      logic [4:0] r;
      r = 5'h00;
      for (int i = SLOTS - 1; i >= 0; i--)
      begin
         if (m[i])
         begin
            r = 5'(i);
         end
      end
      return r;
   endfunction

   // ****************************************
   // next-state logic
   // ****************************************
   always_comb
   begin
      logic [31:0] hit;
      logic [LEN_W-1:0] lmax;
      logic good;
      logic err;
      logic in_rng;
      logic [CNT_W:0] sum;
      logic [CNT_W:0] inc;
      logic [4:0] slot;
      logic [9:0] sel;
      hit = 32'h0000_0000;
      lmax = max_1536_i ? LEN_LONG : LEN_STD;
      err = frm_crc_bad_i | frm_partial_i | frm_symbol_bad_i;
      good = ~err;
      in_rng = (frm_len_i >= LEN_MIN) && (frm_len_i <= lmax);
      sum = '0;
      inc = '0;
      slot = first_slot(s_ff.mask);
      sel = {s_ff.ctl[1:0], reg_wdata_i};
      nxt_s = s_ff;
      store.addr = s_ff.cur_addr;
      store.we = 1'b0;
      store.wdata = '0;

      // frame classification into one hit per counter slot
      if (!frm_tx_i)
      begin
         hit[C_RX_HI_OCT] = frm_hi_prio_i;
         hit[C_RX_SHORT_OK] = (frm_len_i < LEN_MIN) && !frm_crc_bad_i;
         hit[C_RX_SHORT_BAD] = (frm_len_i < LEN_MIN) && err;
         hit[C_RX_LONG_OK] = (frm_len_i > lmax) && !frm_crc_bad_i;
         // short limit checks errors, long limit any frame
         hit[C_RX_LONG_BAD] = max_1536_i ? (frm_len_i > LEN_JAB)
                                : ((frm_len_i > LEN_STD) && err);
         hit[C_RX_SYMBOL] = frm_symbol_bad_i && in_rng;
         hit[C_RX_CHECKSUM] = frm_crc_bad_i && !frm_partial_i
                              && in_rng;
         hit[C_RX_PARTIAL] = frm_crc_bad_i && frm_partial_i
                             && in_rng;
         hit[C_RX_MAC_CTRL] = frm_ctrl_type_i;
         hit[C_RX_PAUSE] = frm_ctrl_type_i && frm_pause_i && !frm_crc_bad_i
                           && (frm_len_i >= LEN_MIN);
         hit[C_RX_ALL_STA] = good && frm_bcast_i;
         hit[C_RX_GROUP] = good && frm_mcast_i && !frm_bcast_i
                           && !frm_ctrl_type_i;
         hit[C_RX_SINGLE] = good && !frm_bcast_i && !frm_mcast_i;
         // length histogram, errored frames included
         hit[C_RX_BIN0] = frm_len_i == LEN_MIN;
         hit[C_RX_BIN0 + 1] = frm_len_i > LEN_MIN
                              && frm_len_i <= LEN_B1;
         hit[C_RX_BIN0 + 2] = frm_len_i > LEN_B1 && frm_len_i <= LEN_B2;
         hit[C_RX_BIN0 + 3] = frm_len_i > LEN_B2 && frm_len_i <= LEN_B3;
         hit[C_RX_BIN0 + 4] = frm_len_i > LEN_B3 && frm_len_i <= LEN_B4;
         hit[C_RX_BIN0 + 5] = frm_len_i > LEN_B4 && frm_len_i <= LEN_STD;
         hit[C_RX_BIN0 + 6] = frm_len_i > LEN_STD && frm_len_i <= LEN_B6;
         hit[C_RX_BIN0 + 7] = frm_len_i > LEN_B6;
      end
      else
      begin
         hit[C_TX_HI_OCT] = frm_hi_prio_i && good;
         hit[C_TX_LATE] = frm_late_hit_i;
         hit[C_TX_PAUSE] = frm_pause_i;
         hit[C_TX_ALL_STA] = good && frm_bcast_i;
         hit[C_TX_GROUP] = good && frm_mcast_i && !frm_bcast_i;
         hit[C_TX_SINGLE] = good && !frm_bcast_i && !frm_mcast_i;
         hit[C_TX_POSTPONED] = frm_postponed_i;
         hit[C_TX_ALL_HITS] = frm_hits_i != 5'h00;
         hit[C_TX_TOO_MANY] = frm_too_many_i;
         hit[C_TX_ONE_HIT] = good && frm_hits_i == 5'h01;
         hit[C_TX_MANY_HITS] = good && !frm_too_many_i
                               && frm_hits_i > 5'h01;
      end

      // ****************************************
      // counter engine
      // ****************************************
      unique case (s_ff.st)
         S_INIT:
         begin
            // sweep clears every counter so reset leaves them zero
            store.addr = s_ff.cur_addr;
            store.we = 1'b1;
            nxt_s.cur_addr = s_ff.cur_addr + 8'h01;
            if (s_ff.cur_addr == STORE_LAST)
            begin
               nxt_s.st = S_IDLE;
               nxt_s.cur_addr = 8'h00;
            end
         end
         S_IDLE:
         begin
            // host reads take precedence over counting
            if (s_ff.host_pend)
            begin
               store.addr = s_ff.host_addr;
               nxt_s.cur_addr = s_ff.host_addr;
               nxt_s.host_pend = 1'b0;
               nxt_s.st = S_HOST;
            end
            else if (s_ff.mask != 32'h0000_0000)
            begin
               store.addr = {s_ff.port, slot};
               nxt_s.cur_addr = {s_ff.port, slot};
               nxt_s.cur_slot = slot;
               nxt_s.st = S_CNT;
            end
         end
         S_HOST:
         begin
            // latch the word, then clear the slot behind it
            nxt_s.word = '0;
            nxt_s.word[WORD_OVF] = store.rdata[CNT_W];
            nxt_s.word[WORD_VALID] = 1'b1;
            nxt_s.word[CNT_W-1:0] = store.rdata[CNT_W-1:0];
            store.we = 1'b1;
            nxt_s.st = S_IDLE;
         end
         S_CNT:
         begin
            if (s_ff.cur_slot == 5'(C_RX_HI_OCT)
                || s_ff.cur_slot == 5'(C_TX_HI_OCT))
            begin
               inc = (CNT_W+1)'(s_ff.len);
            end
            else if (s_ff.cur_slot == 5'(C_TX_ALL_HITS))
            begin
               inc = (CNT_W+1)'(s_ff.hits);
            end
            else
            begin
               inc = (CNT_W+1)'(1);
            end
            sum = {1'b0, store.rdata[CNT_W-1:0]} + inc;
            store.we = 1'b1;
            // overflow is sticky until the read clears it
            store.wdata = {store.rdata[CNT_W] | sum[CNT_W],
                           sum[CNT_W-1:0]};
            nxt_s.mask[s_ff.cur_slot] = 1'b0;
            nxt_s.st = S_IDLE;
         end
      endcase

      // accept a frame report only once the previous one drained
      if (frm_valid_i && s_ff.ready)
      begin
         nxt_s.mask = (frm_port_i < 3'(PORTS)) ? hit : 32'h0000_0000;
         nxt_s.port = frm_port_i;
         nxt_s.len = frm_len_i;
         nxt_s.hits = frm_hits_i;
      end
      nxt_s.ready = (nxt_s.mask == 32'h0000_0000) && (nxt_s.st != S_INIT);

      // ****************************************
      // host register reads
      // ****************************************
      if (reg_rd_i)
      begin
         unique case (reg_addr_i)
            ADDR_CTL: nxt_s.rdata = s_ff.ctl;
            ADDR_OFF: nxt_s.rdata = s_ff.off;
            ADDR_BYTE: nxt_s.rdata = s_ff.dbyte;
            ADDR_WORD0: nxt_s.rdata = s_ff.word[39:32];
            ADDR_WORD1: nxt_s.rdata = s_ff.word[31:24];
            ADDR_WORD2: nxt_s.rdata = s_ff.word[23:16];
            ADDR_WORD3: nxt_s.rdata = s_ff.word[15:8];
            ADDR_WORD4: nxt_s.rdata = s_ff.word[7:0];
            default: nxt_s.rdata = 8'h00;
         endcase
      end

      // ****************************************
      // host register writes and triggers
      // ****************************************
      if (reg_wr_i)
      begin
         unique case (reg_addr_i)
            ADDR_CTL: nxt_s.ctl = reg_wdata_i;
            ADDR_OFF:
            begin
               nxt_s.off = reg_wdata_i;
               if (s_ff.ctl[7:5] == CTL_SEL_ENERGY)
               begin
                  // only the global entry exists, other ports leave the data byte unchanged
                  if (s_ff.ctl[CTL_RD_BIT] && s_ff.ctl[3:0] == 4'h0)
                  begin
                     if (reg_wdata_i == OFF_ENERGY_HI)
                     begin
                        nxt_s.dbyte = s_ff.energy[15:8];
                     end
                     else if (reg_wdata_i == OFF_ENERGY_LO)
                     begin
                        nxt_s.dbyte = s_ff.energy[7:0];
                     end
                     else
                     begin
                        nxt_s.dbyte = 8'h00;
                     end
                  end
               end
               else if (s_ff.ctl[CTL_RD_BIT]
                        && s_ff.ctl[3:2] == CTL_SEL_STATS)
               begin
                  if (sel <= 10'(STORE_LAST))
                  begin
                     nxt_s.host_pend = 1'b1;
                     nxt_s.host_addr = reg_wdata_i;
                  end
                  else
                  begin
                     nxt_s.word = '0;
                  end
               end
            end
            ADDR_BYTE:
            begin
               nxt_s.dbyte = reg_wdata_i;
               // commit only in write mode on the global entry
               if (s_ff.ctl[7:5] == CTL_SEL_ENERGY
                   && !s_ff.ctl[CTL_RD_BIT] && s_ff.ctl[3:0] == 4'h0)
               begin
                  if (s_ff.off == OFF_ENERGY_HI)
                  begin
                     nxt_s.energy[15:8] = reg_wdata_i;
                  end
                  else if (s_ff.off == OFF_ENERGY_LO)
                  begin
                     nxt_s.energy[7:0] = reg_wdata_i;
                  end
               end
            end
            default: nxt_s.dbyte = nxt_s.dbyte;
         endcase
      end
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         s_ff <= '0;
         s_ff.st <= S_INIT;
         s_ff.energy <= ENERGY_RST;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   // outputs come straight from the state flops
   assign reg_rdata_o = s_ff.rdata;
   assign frm_ready_o = s_ff.ready;
   assign energy_global_o = s_ff.energy;

endmodule

// [verilog/mib_pkg.sv]
// constants, field positions and counter slots of the statistics block
// assumes: one clock domain, byte-wide host register port
package mib_pkg;

   // ****************************************
   // host register map
   // ****************************************
   localparam int REG_AW = 8;
   localparam logic [7:0] ADDR_CTL = 8'h6E;
   localparam logic [7:0] ADDR_OFF = 8'h6F;
   localparam logic [7:0] ADDR_BYTE = 8'hA0;
   localparam logic [7:0] ADDR_WORD0 = 8'h74;
   localparam logic [7:0] ADDR_WORD1 = 8'h75;
   localparam logic [7:0] ADDR_WORD2 = 8'h76;
   localparam logic [7:0] ADDR_WORD3 = 8'h77;
   localparam logic [7:0] ADDR_WORD4 = 8'h78;

   // ****************************************
   // control byte fields
   // ****************************************
   localparam int CTL_RD_BIT = 4;
   localparam logic [2:0] CTL_SEL_ENERGY = 3'h1;
   localparam logic [1:0] CTL_SEL_STATS = 2'h3;
   localparam logic [7:0] OFF_ENERGY_HI = 8'h30;
   localparam logic [7:0] OFF_ENERGY_LO = 8'h31;
   localparam logic [15:0] ENERGY_RST = 16'h0000;

   // ****************************************
   // counter store layout
   // ****************************************
   localparam int PORTS = 5;
   localparam int SLOTS = 32;
   localparam int CNT_W = 30;
   localparam int STORE_W = CNT_W + 1;
   localparam int STORE_AW = 8;
   localparam int STORE_DEPTH = PORTS * SLOTS;
   localparam logic [7:0] STORE_LAST = 8'h9F;
   localparam int WORD_OVF = 38;
   localparam int WORD_VALID = 37;

   // ****************************************
   // frame length limits in octets
   // ****************************************
   localparam int LEN_W = 12;
   localparam logic [11:0] LEN_MIN = 12'h040;
   localparam logic [11:0] LEN_STD = 12'h5F2;
   localparam logic [11:0] LEN_LONG = 12'h600;
   localparam logic [11:0] LEN_JAB = 12'h77C;
   localparam logic [11:0] LEN_B1 = 12'h07F;
   localparam logic [11:0] LEN_B2 = 12'h0FF;
   localparam logic [11:0] LEN_B3 = 12'h1FF;
   localparam logic [11:0] LEN_B4 = 12'h3FF;
   localparam logic [11:0] LEN_B6 = 12'h7D0;

   // ****************************************
   // counter slots within one port
   // ****************************************
   localparam int C_RX_HI_OCT = 0;
   localparam int C_RX_SHORT_OK = 1;
   localparam int C_RX_SHORT_BAD = 2;
   localparam int C_RX_LONG_OK = 3;
   localparam int C_RX_LONG_BAD = 4;
   localparam int C_RX_SYMBOL = 5;
   localparam int C_RX_CHECKSUM = 6;
   localparam int C_RX_PARTIAL = 7;
   localparam int C_RX_MAC_CTRL = 8;
   localparam int C_RX_PAUSE = 9;
   localparam int C_RX_ALL_STA = 10;
   localparam int C_RX_GROUP = 11;
   localparam int C_RX_SINGLE = 12;
   localparam int C_RX_BIN0 = 13;
   localparam int C_TX_HI_OCT = 21;
   localparam int C_TX_LATE = 22;
   localparam int C_TX_PAUSE = 23;
   localparam int C_TX_ALL_STA = 24;
   localparam int C_TX_GROUP = 25;
   localparam int C_TX_SINGLE = 26;
   localparam int C_TX_POSTPONED = 27;
   localparam int C_TX_ALL_HITS = 28;
   localparam int C_TX_TOO_MANY = 29;
   localparam int C_TX_ONE_HIT = 30;
   localparam int C_TX_MANY_HITS = 31;

   typedef enum logic [1:0] {S_INIT, S_IDLE, S_HOST, S_CNT} state_t;

endpackage

// [verilog/store_if.sv]
// port bundle between the statistics engine and its counter store
// assumes: read data registered one cycle after the address
`timescale 1ns/1ps
interface store_if #(
   parameter int AW = 8,
   parameter int DW = 31
);
   logic [AW-1:0] addr;
   logic we;
   logic [DW-1:0] wdata;
   logic [DW-1:0] rdata;

   modport master (output addr, output we, output wdata, input rdata);
   modport mem (input addr, input we, input wdata, output rdata);
endinterface

// [verilog/mib_counter_store.sv]
// single-port counter memory with registered read data
// assumes: contents undefined until the engine sweeps it clear
`timescale 1ns/1ps
module mib_counter_store #(
   parameter int DEPTH = 160
) (
   input wire logic ref_clk_i,
   store_if.mem bus
);
   logic [$bits(bus.wdata)-1:0] mem_ff [DEPTH];

   // ****************************************
   // read-before-write, data out of a flop
   // ****************************************
   always_ff @(posedge ref_clk_i)
   begin
      bus.rdata <= mem_ff[bus.addr];
      if (bus.we)
      begin
         mem_ff[bus.addr] <= bus.wdata;
      end
   end
endmodule

// [dv/mib_counter_indirect_access_props.sv]
// checker of the statistics block, bound to the top module's ports
// assumes: single clock, synchronous active-high reset
`timescale 1ns/1ps
module mib_counter_indirect_access_props
   import mib_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [mib_pkg::REG_AW-1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic frm_valid_i,
   input wire logic frm_ready_o,
   input wire logic [2:0] frm_port_i,
   input wire logic frm_tx_i,
   input wire logic [15:0] energy_global_o
);
   // ****************************************
   // host selection tracking
   // ****************************************
   logic [7:0] ctl_ff;
   logic [7:0] off_ff;

   // shadow of the last control and offset bytes the host wrote
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         ctl_ff <= 8'h00;
         off_ff <= 8'h00;
      end
      else if (reg_wr_i && reg_addr_i == ADDR_CTL)
         ctl_ff <= reg_wdata_i;
      else if (reg_wr_i && reg_addr_i == ADDR_OFF)
         off_ff <= reg_wdata_i;
   end

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   a_energy_commit: assert property (
      reg_wr_i && reg_addr_i == ADDR_BYTE && ctl_ff == 8'h20
      && off_ff == OFF_ENERGY_LO |=> energy_global_o[7:0] ==
      $past(reg_wdata_i) && $stable(energy_global_o[15:8]))
      else $error("energy low byte not committed");
   // reset itself also clears the copy, so skip that edge
   a_energy_hold: assert property (
      !$past(sys_rst_i) && $changed(energy_global_o)
      |-> $past(reg_wr_i && reg_addr_i == ADDR_BYTE))
      else $error("energy copy changed without a data write");
   a_energy_hi_rd: assert property (
      reg_rd_i && reg_addr_i == ADDR_BYTE && ctl_ff == 8'h30
      && off_ff == OFF_ENERGY_HI
      |=> reg_rdata_o == $past(energy_global_o[15:8]))
      else $error("energy upper byte read wrong");
   a_energy_lo_rd: assert property (
      reg_rd_i && reg_addr_i == ADDR_BYTE && ctl_ff == 8'h30
      && off_ff == OFF_ENERGY_LO
      |=> reg_rdata_o == $past(energy_global_o[7:0]))
      else $error("energy lower byte read wrong");
   a_rdata_hold: assert property (
      !reg_rd_i |=> $stable(reg_rdata_o))
      else $error("read data moved without a read");
   a_word_top: assert property (
      reg_rd_i && reg_addr_i == ADDR_WORD0 && ctl_ff == 8'h1C
      && off_ff <= STORE_LAST
      |=> reg_rdata_o[7] == 1'b0 && reg_rdata_o[5:0] == 6'h20)
      else $error("counter word top byte malformed");
   a_word_second: assert property (
      reg_rd_i && reg_addr_i == ADDR_WORD1 && ctl_ff == 8'h1C
      |=> reg_rdata_o[7:6] == 2'b00)
      else $error("counter word bits 31 and 30 not zero");
   // every received report on a real port hits at least one counter
   a_ready_drop: assert property (
      frm_valid_i && frm_ready_o && !frm_tx_i && frm_port_i < 3'd5
      |=> !frm_ready_o [*2])
      else $error("report taken without a counter update");
   a_ready_back: assert property (
      $fell(frm_ready_o) |-> ##[1:300] frm_ready_o)
      else $error("report port stuck busy");

   c_energy_write: cover property (reg_wr_i && reg_addr_i == ADDR_BYTE);
   c_word_read: cover property (reg_rd_i && reg_addr_i == ADDR_WORD4);
   c_tx_taken: cover property (frm_valid_i && frm_ready_o && frm_tx_i);
endmodule

bind mib_counter_indirect_access mib_counter_indirect_access_props props (.*);

// [dv/host_model.sv]
// host processor model on the byte-wide register port
// assumes: strobes sampled on the rising edge, one access at a time
`timescale 1ns/1ps
module host_model (
   input wire logic ref_clk_i,
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [7:0] reg_addr_o,
   output logic [7:0] reg_wdata_o,
   input wire logic [7:0] reg_rdata_i
);
   import mib_pkg::*;

   // idle bus at time zero
   initial
   begin
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
   end

   // released lines show the inverse so a stale value is never trusted
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      reg_wr_o <= 1'b1;
      reg_addr_o <= a;
      reg_wdata_o <= d;
      @(posedge ref_clk_i);
      reg_wr_o <= 1'b0;
      reg_addr_o <= ~a;
      reg_wdata_o <= ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk_i);
      reg_rd_o <= 1'b1;
      reg_addr_o <= a;
      @(posedge ref_clk_i);
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~a;
      @(posedge ref_clk_i);
      d = reg_rdata_i;
   endtask

   // the wait covers a frame update that delays the fetch
   task automatic ctr_read(input logic [7:0] a, output logic [39:0] w);
      logic [7:0] b;
      wr(ADDR_CTL, 8'h1C);
      wr(ADDR_OFF, a);
      repeat (8) @(posedge ref_clk_i);
      for (int i = 0; i < 5; i++)
      begin
         rd(ADDR_WORD0 + 8'(i), b);
         w = {w[31:0], b};
      end
   endtask

   task automatic energy_write(input logic [7:0] v);
      wr(ADDR_CTL, 8'h20);
      wr(ADDR_OFF, OFF_ENERGY_LO);
      wr(ADDR_BYTE, v);
   endtask

   task automatic energy_read(input logic [7:0] off, output logic [7:0] b);
      wr(ADDR_CTL, 8'h30);
      wr(ADDR_OFF, off);
      rd(ADDR_BYTE, b);
   endtask
endmodule

// [dv/tb_mib_counter_indirect_access.sv]
// self-checking bench of the statistics block
// assumes: host model drives the register port, bench drives reports
`timescale 1ns/1ps
module tb_mib_counter_indirect_access;
   import mib_pkg::*;
   logic ref_clk_i, sys_rst_i, reg_wr_i, reg_rd_i, frm_valid_i;
   logic frm_ready_o, frm_tx_i, max_1536_i;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
   logic [2:0] frm_port_i;
   logic [11:0] frm_len_i;
   logic [4:0] frm_hits_i;
   logic [15:0] energy_global_o;
   logic frm_crc_bad_i, frm_partial_i, frm_symbol_bad_i, frm_hi_prio_i;
   logic frm_bcast_i, frm_mcast_i, frm_ctrl_type_i, frm_pause_i;
   logic frm_late_hit_i, frm_postponed_i, frm_too_many_i;
   logic [10:0] flg;
   int fail_count, checks_done, cycles;

   // ****************************************
   // harness
   // ****************************************
   // one flag vector keeps report calls short
   assign {frm_crc_bad_i, frm_partial_i, frm_symbol_bad_i, frm_hi_prio_i,
      frm_bcast_i, frm_mcast_i, frm_ctrl_type_i, frm_pause_i,
      frm_late_hit_i, frm_postponed_i, frm_too_many_i} = flg;

   host_model host (.ref_clk_i(ref_clk_i), .reg_wr_o(reg_wr_i),
      .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i),
      .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o));
   mib_counter_indirect_access dut (.*);

   always #4 ref_clk_i = ~ref_clk_i;

   // hang guard, far above the roughly 1300 cycles the tests need
   always @(posedge ref_clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fail_count++;
         $display("unexpected at %0t: run timed out", $time);
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic cmp(input logic [39:0] g, input logic [39:0] e,
      input string m);
      checks_done++;
      if (g !== e)
      begin
         fail_count++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
      end
   endtask

   // flags: crc partial symbol hi bcast mcast ctrl pause late post many
   task automatic send(input logic [2:0] p, input logic tx,
      input logic [11:0] len, input logic [10:0] f, input logic [4:0] h);
      @(posedge ref_clk_i);
      frm_valid_i <= 1'b1;
      frm_port_i <= p;
      frm_tx_i <= tx;
      frm_len_i <= len;
      flg <= f;
      frm_hits_i <= h;
      do @(posedge ref_clk_i); while (frm_ready_o !== 1'b1);
      frm_valid_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      while (frm_ready_o !== 1'b1) @(posedge ref_clk_i);
   endtask

   // counter word: overflow clear, valid set, reserved zero
   task automatic chk(input int p, input int s, input logic [29:0] n);
      logic [39:0] w;
      host.ctr_read(8'(p * 32 + s), w);
      cmp(w, {3'b001, 7'h00, n}, "counter word");
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_energy();
      logic [7:0] b;
      host.energy_write(8'h5A);
      @(posedge ref_clk_i);
      cmp(40'(energy_global_o), 40'h5A, "energy copy");
      host.rd(ADDR_CTL, b);
      cmp(40'(b), 40'h30 - 40'h10, "control readback");
      host.energy_read(OFF_ENERGY_LO, b);
      cmp(40'(b), 40'h5A, "energy low byte");
      host.energy_read(OFF_ENERGY_HI, b);
      cmp(40'(b), 40'h00, "energy high byte");
      host.rd(8'h10, b);
      cmp(40'(b), 40'h00, "unmapped read");
   endtask

   task automatic t_rx_port();
      send(1, 0, 64, 11'h0C0, 0);
      send(1, 0, 100, 11'h080, 0);
      chk(1, C_RX_HI_OCT, 164);
      chk(1, C_RX_ALL_STA, 1);
      chk(1, C_RX_SINGLE, 1);
      chk(1, C_RX_BIN0, 1);
      chk(1, C_RX_HI_OCT, 0);
   endtask

   task automatic t_sizes();
      max_1536_i <= 1'b0;
      send(0, 0, 1530, 0, 0);
      chk(0, C_RX_LONG_OK, 1);
      max_1536_i <= 1'b1;
      send(0, 0, 1530, 0, 0);
      chk(0, C_RX_LONG_OK, 0);
      send(0, 0, 2000, 0, 0);
      chk(0, C_RX_LONG_OK, 1);
      chk(0, C_RX_LONG_BAD, 1);
      send(0, 0, 40, 0, 0);
      send(0, 0, 40, 11'h400, 0);
      chk(0, C_RX_SHORT_OK, 1);
      chk(0, C_RX_SHORT_BAD, 1);
   endtask

   task automatic t_bins();
      logic [11:0] lens [8] = '{64, 100, 200, 300, 600, 1100, 1600, 2100};
      for (int i = 0; i < 8; i++)
         send(4, 0, lens[i], 0, 0);
      for (int i = 0; i < 8; i++)
         chk(4, C_RX_BIN0 + i, 1);
      send(3, 0, 64, 11'h030, 0);
      chk(3, C_RX_MAC_CTRL, 1);
      chk(3, C_RX_GROUP, 0);
      send(3, 0, 64, 11'h018, 0);
      chk(3, C_RX_PAUSE, 1);
      send(3, 0, 100, 11'h700, 0);
      chk(3, C_RX_SYMBOL, 1);
      chk(3, C_RX_PARTIAL, 1);
      chk(3, C_RX_CHECKSUM, 0);
   endtask

   task automatic t_tx();
      send(2, 1, 64, 11'h008, 0);
      send(2, 1, 64, 0, 1);
      send(2, 1, 64, 0, 3);
      send(2, 1, 64, 11'h002, 0);
      send(2, 1, 64, 11'h004, 0);
      chk(2, C_TX_PAUSE, 1);
      chk(2, C_TX_ONE_HIT, 1);
      chk(2, C_TX_MANY_HITS, 1);
      chk(2, C_TX_ALL_HITS, 4);
      chk(2, C_TX_POSTPONED, 1);
      chk(2, C_TX_LATE, 1);
      send(2, 1, 64, 11'h001, 16);
      chk(2, C_TX_TOO_MANY, 1);
      chk(2, C_TX_ALL_HITS, 16);
   endtask

   // reset, wait out the clearing sweep, then run each scenario
   initial
   begin
      ref_clk_i = 1'b0;
      sys_rst_i = 1'b1;
      frm_valid_i = 1'b0;
      frm_port_i = 3'h0;
      frm_tx_i = 1'b0;
      frm_len_i = 12'h000;
      flg = 11'h000;
      frm_hits_i = 5'h00;
      max_1536_i = 1'b0;
      repeat (4) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge ref_clk_i);
      while (frm_ready_o !== 1'b1) @(posedge ref_clk_i);
      t_energy();
      $display("energy window test done");
      t_rx_port();
      $display("receive octet test done");
      t_sizes();
      $display("frame size test done");
      t_bins();
      $display("histogram and control test done");
      t_tx();
      $display("transmit test done");
      end_sim();
   end
endmodule
